//--- rma_pkg.sv
// Shared constants and types for the real-mode address generator.
// Assumes a single 10 MHz core clock and an active-low asynchronous reset.
package rma_pkg;

	// Address formation
	localparam int          RMA_SEG_SHIFT     = 4;          // Selector to base shift
	localparam int          RMA_PHYS_W        = 21;         // Physical address width incl. bit 20
	localparam int          RMA_MASK_BIT      = 20;         // Bit gated by the external mask
	localparam logic [15:0] RMA_OFS_MAX       = 16'hffff;   // Largest legal real-mode offset

	// Pseudo-protection fault vectors
	localparam logic [7:0]  RMA_VEC_STACK_FLT = 8'h0c;      // Stack-segment reference out of range
	localparam logic [7:0]  RMA_VEC_GEN_FLT   = 8'h0d;      // Any other reference out of range

	// Interrupt table
	localparam logic [31:0] RMA_TBL_BASE_RST  = 32'h00000000;
	localparam logic [15:0] RMA_TBL_LIMIT_RST = 16'h03ff;
	localparam int          RMA_ENTRY_SHIFT   = 2;          // Four-byte entries

	// Stack and register reset values
	localparam logic [15:0] RMA_STACK_STEP    = 16'h0002;   // One 16-bit stack slot
	localparam logic [31:0] RMA_FLAGS_RST     = 32'h00000002;
	localparam logic [31:0] RMA_EIP_RST       = 32'h0000fff0;
	localparam logic [15:0] RMA_CS_RST        = 16'hf000;
	localparam logic [15:0] RMA_SP_RST        = 16'h0000;

	// Flag word bit positions cleared on handler entry
	localparam int          RMA_FL_TRAP       = 8;
	localparam int          RMA_FL_IEN        = 9;
	localparam int          RMA_FL_RESUME     = 16;
	localparam int          RMA_FL_ALIGN      = 18;

	// Requests from the core sequencer
	typedef enum logic [2:0] {
		OP_MEM, OP_CALL_NEAR, OP_CALL_FAR, OP_RET_NEAR,
		OP_RET_FAR, OP_INT, OP_INT_RETURN, OP_LOAD_TABLE
	} rma_op_t;

	// Bus sequencer states
	typedef enum logic [3:0] {
		ST_IDLE, ST_MEM, ST_PUSH_FL, ST_PUSH_CS, ST_PUSH_IP,
		ST_VEC_IP, ST_VEC_CS, ST_POP_IP, ST_POP_CS, ST_POP_FL
	} rma_state_t;

endpackage : rma_pkg

//--- rma_real_mode_gen.sv
// Real-address-mode address formation and stack/interrupt sequencer.
// Assumes a synchronous memory bus on I_CLK_SYS; the mask pin is asynchronous.
`timescale 1ns/1ps
module rma_real_mode_gen
	import rma_pkg::*;
(
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_NRST,
	input  wire logic        I_PROT_ENABLE,
	input  wire logic        I_ADDR_BIT20_MASK_N,
	input  wire logic        I_REQ_VALID,
	input  wire logic [2:0]  I_REQ_OP,
	input  wire logic        I_OPSIZE32,
	input  wire logic        I_ADDR32,
	input  wire logic        I_STACK_REF,
	input  wire logic [15:0] I_SEG,
	input  wire logic [31:0] I_OFS,
	input  wire logic        I_MEM_WRITE,
	input  wire logic [15:0] I_WDATA,
	input  wire logic [15:0] I_STACK_SEG,
	input  wire logic [15:0] I_TARGET_CS,
	input  wire logic [15:0] I_TARGET_IP,
	input  wire logic [7:0]  I_VECTOR,
	input  wire logic [31:0] I_TABLE_BASE,
	input  wire logic [15:0] I_TABLE_LIMIT,
	input  wire logic [15:0] I_MEM_RDATA,
	input  wire logic        I_MEM_READY,
	output logic             O_REQ_READY,
	output logic             O_DONE,
	output logic             O_FAULT,
	output logic [7:0]       O_FAULT_VEC,
	output logic [15:0]      O_RDATA,
	output logic [20:0]      O_MEM_ADDR,
	output logic             O_MEM_RD,
	output logic             O_MEM_WR,
	output logic [15:0]      O_MEM_WDATA,
	output logic             O_REAL_MODE,
	output logic             O_WIDE_OPERAND,
	output logic [31:0]      O_EXT_INSTR_POINTER,
	output logic [15:0]      O_SHORT_INSTR_POINTER,
	output logic [15:0]      O_CODE_SEG,
	output logic [31:0]      O_EXT_FLAG_WORD,
	output logic [15:0]      O_STACK_OFFSET_REG,
	output logic [31:0]      O_TABLE_BASE,
	output logic [15:0]      O_TABLE_LIMIT
);

	// Selector shifted into a base, plus a 16-bit offset; the top bit keeps the carry
	function automatic logic [RMA_PHYS_W-1:0] rma_phys(input logic [15:0] seg, input logic [15:0] ofs);
		return {1'b0, seg, 4'h0} + {5'h00, ofs};
	endfunction : rma_phys

	// Table entry word address: base plus vector scaled by four, plus two for the segment half
	function automatic logic [RMA_PHYS_W-1:0] rma_vec(input logic [31:0] base, input logic [7:0] vec,
		input logic hi);
		return base[RMA_PHYS_W-1:0] + {11'h000, vec, hi, 1'b0};
	endfunction : rma_vec

	rma_state_t        st_q, st_d;
	rma_op_t           op_q, op_d, req_op;
	logic [31:0]       eip_q, eip_d, flags_q, flags_d, tbase_q, tbase_d;
	logic [15:0]       cs_q, cs_d, sp_q, sp_d, tlimit_q, tlimit_d, ss_q, ss_d;
	logic [15:0]       tcs_q, tcs_d, tip_q, tip_d, rdata_q, rdata_d, wdata_q, wdata_d;
	logic [7:0]        vec_q, vec_d, fvec_q, fvec_d;
	logic [20:0]       addr_q, addr_d, raw_addr;
	logic              rd_q, rd_d, wr_q, wr_d, done_q, done_d, fault_q, fault_d;
	logic              real_q, real_d, wide_q, wide_d;
	logic              mask_s1_q, mask_s2_q;
	logic              range_bad, limit_bad;

	assign req_op    = rma_op_t'(I_REQ_OP);
	// Wide offsets are allowed but must still land inside the 16-bit range
	assign range_bad = real_q && I_ADDR32 && (I_OFS[31:16] != 16'h0000);
	// An entry whose last byte passes the limit cannot be fetched
	// Judged against the loaded limit, not the load port, which may already hold the next value
	assign limit_bad = ({6'h00, I_VECTOR, 2'b11} > tlimit_q);

	// Mask pin synchroniser; the first stage feeds only the second
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			mask_s1_q <= 1'b1;
			mask_s2_q <= 1'b1;
		end else begin
			mask_s1_q <= I_ADDR_BIT20_MASK_N;
			mask_s2_q <= mask_s1_q;
		end
	end

	// Next-state logic: request decode, step completion, then bus setup for the coming state
	always_comb begin
		st_d     = st_q;
		op_d     = op_q;
		eip_d    = eip_q;
		flags_d  = flags_q;
		tbase_d  = tbase_q;
		tlimit_d = tlimit_q;
		cs_d     = cs_q;
		sp_d     = sp_q;
		ss_d     = ss_q;
		tcs_d    = tcs_q;
		tip_d    = tip_q;
		rdata_d  = rdata_q;
		wdata_d  = wdata_q;
		vec_d    = vec_q;
		fvec_d   = fvec_q;
		addr_d   = addr_q;
		rd_d     = rd_q;
		wr_d     = wr_q;
		done_d   = 1'b0;
		fault_d  = 1'b0;
		wide_d   = wide_q;
		raw_addr = addr_q;
		real_d   = !I_PROT_ENABLE;
		case (st_q)
			ST_IDLE: begin
				if (I_REQ_VALID) begin
					op_d   = req_op;
					vec_d  = I_VECTOR;
					tcs_d  = I_TARGET_CS;
					tip_d  = I_TARGET_IP;
					ss_d   = I_STACK_SEG;
					wide_d = I_OPSIZE32;
					case (req_op)
						OP_MEM: begin
							if (range_bad) begin
								fault_d = 1'b1;
								fvec_d  = I_STACK_REF ? RMA_VEC_STACK_FLT : RMA_VEC_GEN_FLT;
							end else begin
								st_d     = ST_MEM;
								raw_addr = rma_phys(I_SEG, I_OFS[15:0]);
								rd_d     = !I_MEM_WRITE;
								wr_d     = I_MEM_WRITE;
								wdata_d  = I_WDATA;
							end
						end
						OP_CALL_NEAR: st_d = ST_PUSH_IP;
						OP_CALL_FAR:  st_d = ST_PUSH_CS;
						OP_RET_NEAR, OP_RET_FAR, OP_INT_RETURN: st_d = ST_POP_IP;
						OP_INT: begin
							if (limit_bad) begin
								fault_d = 1'b1;
								fvec_d  = RMA_VEC_GEN_FLT;
							end else begin
								st_d = ST_PUSH_FL;
							end
						end
						OP_LOAD_TABLE: begin
							tbase_d  = I_TABLE_BASE;
							tlimit_d = I_TABLE_LIMIT;
							done_d   = 1'b1;
						end
						default: st_d = ST_IDLE;
					endcase
				end
			end
			default: begin
				if (I_MEM_READY) begin
					case (st_q)
						ST_MEM: begin
							if (rd_q) begin
								rdata_d = I_MEM_RDATA;
							end
							st_d = ST_IDLE;
						end
						ST_PUSH_FL: begin
							sp_d = sp_q - RMA_STACK_STEP;
							st_d = ST_PUSH_CS;
						end
						ST_PUSH_CS: begin
							sp_d = sp_q - RMA_STACK_STEP;
							st_d = ST_PUSH_IP;
						end
						ST_PUSH_IP: begin
							sp_d = sp_q - RMA_STACK_STEP;
							if (op_q == OP_INT) begin
								// Cleared only now so the pushed image holds the old flags
								flags_d[RMA_FL_IEN]    = 1'b0;
								flags_d[RMA_FL_TRAP]   = 1'b0;
								flags_d[RMA_FL_RESUME] = 1'b0;
								flags_d[RMA_FL_ALIGN]  = 1'b0;
								st_d = ST_VEC_IP;
							end else begin
								eip_d = {16'h0000, tip_q};
								if (op_q == OP_CALL_FAR) begin
									cs_d = tcs_q;
								end
								st_d = ST_IDLE;
							end
						end
						ST_VEC_IP: begin
							eip_d = {16'h0000, I_MEM_RDATA};
							st_d  = ST_VEC_CS;
						end
						ST_VEC_CS: begin
							cs_d = I_MEM_RDATA;
							st_d = ST_IDLE;
						end
						ST_POP_IP: begin
							eip_d = {16'h0000, I_MEM_RDATA};
							sp_d  = sp_q + RMA_STACK_STEP;
							st_d  = (op_q == OP_RET_NEAR) ? ST_IDLE : ST_POP_CS;
						end
						ST_POP_CS: begin
							cs_d = I_MEM_RDATA;
							sp_d = sp_q + RMA_STACK_STEP;
							st_d = (op_q == OP_INT_RETURN) ? ST_POP_FL : ST_IDLE;
						end
						ST_POP_FL: begin
							flags_d[15:0] = I_MEM_RDATA;
							sp_d          = sp_q + RMA_STACK_STEP;
							st_d          = ST_IDLE;
						end
						default: st_d = ST_IDLE;
					endcase
					done_d = (st_d == ST_IDLE);
				end
			end
		endcase
		// Bus setup for the state being entered; push slots sit below the current offset, pops read at it
		case (st_d)
			ST_IDLE: begin
				rd_d = 1'b0;
				wr_d = 1'b0;
			end
			ST_PUSH_FL, ST_PUSH_CS, ST_PUSH_IP: begin
				rd_d     = 1'b0;
				wr_d     = 1'b1;
				raw_addr = rma_phys(ss_d, sp_d - RMA_STACK_STEP);
				if (st_d == ST_PUSH_FL) begin
					wdata_d = flags_d[15:0];
				end else if (st_d == ST_PUSH_CS) begin
					wdata_d = cs_d;
				end else begin
					wdata_d = eip_d[15:0];
				end
			end
			ST_VEC_IP, ST_VEC_CS: begin
				rd_d     = 1'b1;
				wr_d     = 1'b0;
				raw_addr = rma_vec(tbase_d, vec_d, (st_d == ST_VEC_CS));
			end
			ST_POP_IP, ST_POP_CS, ST_POP_FL: begin
				rd_d     = 1'b1;
				wr_d     = 1'b0;
				raw_addr = rma_phys(ss_d, sp_d);
			end
			default: begin
			end
		endcase
		// The mask gates only bit 20 and only while real mode holds
		addr_d = raw_addr;
		addr_d[RMA_MASK_BIT] = raw_addr[RMA_MASK_BIT] & ~(real_d & ~mask_s2_q);
	end

	// State registers
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			st_q     <= ST_IDLE;
			op_q     <= OP_MEM;
			eip_q    <= RMA_EIP_RST;
			flags_q  <= RMA_FLAGS_RST;
			tbase_q  <= RMA_TBL_BASE_RST;
			tlimit_q <= RMA_TBL_LIMIT_RST;
			cs_q     <= RMA_CS_RST;
			sp_q     <= RMA_SP_RST;
			ss_q     <= 16'h0000;
			tcs_q    <= 16'h0000;
			tip_q    <= 16'h0000;
			rdata_q  <= 16'h0000;
			wdata_q  <= 16'h0000;
			vec_q    <= 8'h00;
			fvec_q   <= 8'h00;
			addr_q   <= 21'h00000;
			rd_q     <= 1'b0;
			wr_q     <= 1'b0;
			done_q   <= 1'b0;
			fault_q  <= 1'b0;
			real_q   <= 1'b1;
			wide_q   <= 1'b0;
		end else begin
			st_q     <= st_d;
			op_q     <= op_d;
			eip_q    <= eip_d;
			flags_q  <= flags_d;
			tbase_q  <= tbase_d;
			tlimit_q <= tlimit_d;
			cs_q     <= cs_d;
			sp_q     <= sp_d;
			ss_q     <= ss_d;
			tcs_q    <= tcs_d;
			tip_q    <= tip_d;
			rdata_q  <= rdata_d;
			wdata_q  <= wdata_d;
			vec_q    <= vec_d;
			fvec_q   <= fvec_d;
			addr_q   <= addr_d;
			rd_q     <= rd_d;
			wr_q     <= wr_d;
			done_q   <= done_d;
			fault_q  <= fault_d;
			real_q   <= real_d;
			wide_q   <= wide_d;
		end
	end

	// Outputs; ready is combinational so a request is taken in the idle cycle itself
	assign O_REQ_READY           = (st_q == ST_IDLE);
	assign O_DONE                = done_q;
	assign O_FAULT               = fault_q;
	assign O_FAULT_VEC           = fvec_q;
	assign O_RDATA               = rdata_q;
	assign O_MEM_ADDR            = addr_q;
	assign O_MEM_RD              = rd_q;
	assign O_MEM_WR              = wr_q;
	assign O_MEM_WDATA           = wdata_q;
	assign O_REAL_MODE           = real_q;
	assign O_WIDE_OPERAND        = wide_q;
	assign O_EXT_INSTR_POINTER   = eip_q;
	assign O_SHORT_INSTR_POINTER = eip_q[15:0];
	assign O_CODE_SEG            = cs_q;
	assign O_EXT_FLAG_WORD       = flags_q;
	assign O_STACK_OFFSET_REG    = sp_q;
	assign O_TABLE_BASE          = tbase_q;
	assign O_TABLE_LIMIT         = tlimit_q;

	// Helpers seen only by the checks below
	logic [20:0] chk_mem_addr, chk_vec_addr;
	logic        take;
	assign chk_mem_addr = rma_phys(I_SEG, I_OFS[15:0]);
	assign chk_vec_addr = rma_vec(tbase_q, vec_q, 1'b0);
	assign take         = I_REQ_VALID && (st_q == ST_IDLE);

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_NRST);

	property p_mask_bit20;
		(O_MEM_RD || O_MEM_WR) && real_q && !mask_s2_q && $past(!mask_s2_q) |-> !O_MEM_ADDR[20];
	endproperty
	a_mask_bit20: assert property (p_mask_bit20) else $error("Masked bit 20 driven high");

	property p_mem_addr;
		take && req_op == OP_MEM && !range_bad |=> O_MEM_ADDR[19:0] == $past(chk_mem_addr[19:0]);
	endproperty
	a_mem_addr: assert property (p_mem_addr) else $error("Segment address formed wrongly");

	property p_range_fault;
		take && req_op == OP_MEM && range_bad |=> O_FAULT && !O_MEM_RD && !O_MEM_WR
			&& (O_FAULT_VEC == RMA_VEC_STACK_FLT || O_FAULT_VEC == RMA_VEC_GEN_FLT);
	endproperty
	a_range_fault: assert property (p_range_fault) else $error("Offset range fault missing");

	property p_push_down;
		O_MEM_WR && I_MEM_READY && st_q inside {ST_PUSH_FL, ST_PUSH_CS, ST_PUSH_IP}
			|=> sp_q == $past(sp_q) - RMA_STACK_STEP;
	endproperty
	a_push_down: assert property (p_push_down) else $error("Push did not lower stack offset");

	property p_call_push;
		take && req_op == OP_CALL_NEAR |=> O_MEM_WR && O_MEM_WDATA == $past(eip_q[15:0]);
	endproperty
	a_call_push: assert property (p_call_push) else $error("Call did not push pointer");

	property p_ret_pop;
		st_q == ST_POP_IP && I_MEM_READY |=> eip_q == {16'h0000, $past(I_MEM_RDATA)};
	endproperty
	a_ret_pop: assert property (p_ret_pop) else $error("Return pop not loaded");

	property p_int_clear;
		$rose(st_q == ST_VEC_IP) |-> !flags_q[RMA_FL_IEN] && $past(O_MEM_WR);
	endproperty
	a_int_clear: assert property (p_int_clear) else $error("Enable flag not cleared");

	property p_vec_addr;
		st_q == ST_VEC_IP |-> O_MEM_RD && O_MEM_ADDR[19:0] == chk_vec_addr[19:0];
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("Table entry address wrong");

	property p_int_return_flags;
		st_q == ST_POP_FL && I_MEM_READY |=> flags_q[15:0] == $past(I_MEM_RDATA) && st_q == ST_IDLE && O_DONE;
	endproperty
	a_int_return_flags: assert property (p_int_return_flags) else $error("Flag image not restored");

endmodule : rma_real_mode_gen

//--- rma_mem_model.sv
// Behavioural physical memory on the far side of the address generator's bus.
// Assumes each word request is held until ready; the bench sets the wait states.
`timescale 1ns/1ps
module rma_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [20:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [3:0]  i_wait,
	output logic             o_ready,
	output logic [15:0]      o_rdata
);
	logic [15:0] mem [int];
	logic [3:0]  cnt_q;
	logic [15:0] last_q;
	logic [20:0] last_addr_q;

	// Ready once the chosen wait has passed; zero wait answers at once
	assign o_ready = (i_rd | i_wr) && (cnt_q == i_wait);
	// Outside a read the line shows the inverse of the last word, so a stale copy never matches
	assign o_rdata = (o_ready && i_rd) ? (mem.exists(i_addr) ? mem[i_addr] : 16'h0000) : ~last_q;

	// Wait counter and word commit; last address kept for the bench
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= 4'h0;
			last_q <= 16'h0000;
			last_addr_q <= 21'h000000;
		end else if (o_ready) begin
			cnt_q <= 4'h0;
			last_q <= o_rdata;
			last_addr_q <= i_addr;
			if (i_wr)
				mem[i_addr] = i_wdata;
		end else if (i_rd | i_wr)
			cnt_q <= cnt_q + 4'h1;
		else
			cnt_q <= 4'h0;
	end
endmodule : rma_mem_model

//--- tb.sv
// Self-checking bench for the real-mode address generator.
// Assumes the memory model answers every bus word; 10 MHz clock.
`timescale 1ns/1ps
module tb
	import rma_pkg::*;
();
	logic        clk, nrst, prot, mask_n, valid, opsz, a32, sref, wr_req, mready;
	logic        ready, done, fault, mem_rd, mem_wr, real_m, wide, got_fault;
	logic [2:0]  op;
	logic [3:0]  wt;
	logic [7:0]  vec, fvec;
	logic [15:0] seg, wdat, ss, tcs, tip, tlim, mrdata, rdata, mwdata, ip16, cs, sp, lim;
	logic [20:0] maddr;
	logic [31:0] ofs, tbase, ext_instr_pointer, flags, base;
	int          bad_count, n_checks;

	rma_real_mode_gen u_dut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_PROT_ENABLE(prot),
		.I_ADDR_BIT20_MASK_N(mask_n), .I_REQ_VALID(valid), .I_REQ_OP(op), .I_OPSIZE32(opsz),
		.I_ADDR32(a32), .I_STACK_REF(sref), .I_SEG(seg), .I_OFS(ofs), .I_MEM_WRITE(wr_req),
		.I_WDATA(wdat), .I_STACK_SEG(ss), .I_TARGET_CS(tcs), .I_TARGET_IP(tip), .I_VECTOR(vec),
		.I_TABLE_BASE(tbase), .I_TABLE_LIMIT(tlim), .I_MEM_RDATA(mrdata), .I_MEM_READY(mready),
		.O_REQ_READY(ready), .O_DONE(done), .O_FAULT(fault), .O_FAULT_VEC(fvec), .O_RDATA(rdata),
		.O_MEM_ADDR(maddr), .O_MEM_RD(mem_rd), .O_MEM_WR(mem_wr), .O_MEM_WDATA(mwdata),
		.O_REAL_MODE(real_m), .O_WIDE_OPERAND(wide), .O_EXT_INSTR_POINTER(ext_instr_pointer),
		.O_SHORT_INSTR_POINTER(ip16), .O_CODE_SEG(cs), .O_EXT_FLAG_WORD(flags),
		.O_STACK_OFFSET_REG(sp), .O_TABLE_BASE(base), .O_TABLE_LIMIT(lim));

	rma_mem_model u_mem (.i_clk(clk), .i_nrst(nrst), .i_rd(mem_rd), .i_wr(mem_wr), .i_addr(maddr),
		.i_wdata(mwdata), .i_wait(wt), .o_ready(mready), .o_rdata(mrdata));

	// Free-running core clock
	always #50 clk = ~clk;

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One request, called at a clock edge; waits a bounded time for done or fault
	task automatic run(input logic [2:0] o);
		op <= o;
		valid <= 1'b1;
		@(posedge clk);
		valid <= 1'b0;
		#1;
		// Fault and table load answer one cycle after the take, so look before waiting
		for (int i = 0; i < 60; i++) begin
			if (done === 1'b1 || fault === 1'b1)
				break;
			@(posedge clk);
			#1;
		end
		got_fault = fault;
		chk({31'h0, done | fault}, 32'h1);
	endtask : run

	// Mask pin changes pass two synchroniser flops before use
	task automatic set_mask(input logic m);
		@(posedge clk);
		mask_n <= m;
		repeat (3) @(posedge clk);
	endtask : set_mask

	task automatic t_reset;
		chk(real_m, 1'b1);
		chk(base, 32'h0);
		chk(lim, 16'h03ff);
		chk(ip16, RMA_EIP_RST[15:0]);
		chk(ext_instr_pointer, RMA_EIP_RST);
		chk(ready, 1'b1);
		chk({mem_rd, mem_wr}, 2'b00);
	endtask : t_reset

	// Carry into bit 20 kept, then masked off by the pin; slow memory on the first read
	task automatic t_mem;
		u_mem.mem[21'h10ffef] = 16'hbeef;
		@(posedge clk);
		seg <= 16'hffff;
		ofs <= 32'h0000ffff;
		wt <= 4'h3;
		opsz <= 1'b1;
		run(OP_MEM);
		chk(u_mem.last_addr_q, 32'h0010ffef);
		chk(rdata, 16'hbeef);
		chk(wide, 1'b1);
		set_mask(1'b0);
		wr_req <= 1'b1;
		wdat <= 16'ha5a5;
		wt <= 4'h0;
		run(OP_MEM);
		chk(u_mem.mem[21'h0ffef], 16'ha5a5);
		chk(u_mem.mem[21'h10ffef], 16'hbeef);
	endtask : t_mem

	// Wide offsets: past FFFFH faults with 12 or 13, FFFFH itself is formed
	task automatic t_fault;
		@(posedge clk);
		wr_req <= 1'b0;
		seg <= 16'h0000;
		a32 <= 1'b1;
		sref <= 1'b1;
		ofs <= 32'h00010000;
		run(OP_MEM);
		chk({got_fault, fvec}, {1'b1, RMA_VEC_STACK_FLT});
		@(posedge clk);
		sref <= 1'b0;
		run(OP_MEM);
		chk({got_fault, fvec}, {1'b1, RMA_VEC_GEN_FLT});
		@(posedge clk);
		ofs <= 32'h0000ffff;
		run(OP_MEM);
		chk({got_fault, u_mem.last_addr_q}, {1'b0, 21'h00ffff});
		@(posedge clk);
		a32 <= 1'b0;
	endtask : t_fault

	// Near and far calls push down the stack, returns pop in reverse
	task automatic t_calls;
		@(posedge clk);
		tip <= 16'h1234;
		run(OP_CALL_NEAR);
		chk(u_mem.mem[21'h1fffe], 16'hfff0);
		chk({sp, ext_instr_pointer}, {16'hfffe, 32'h00001234});
		@(posedge clk);
		tcs <= 16'h2000;
		tip <= 16'h0100;
		wt <= 4'h2;
		run(OP_CALL_FAR);
		chk({u_mem.mem[21'h1fffc], u_mem.mem[21'h1fffa]}, {16'hf000, 16'h1234});
		chk({sp, cs}, {16'hfffa, 16'h2000});
		@(posedge clk);
		run(OP_RET_FAR);
		chk({sp, cs, ext_instr_pointer}, {16'hfffe, 16'hf000, 32'h00001234});
		@(posedge clk);
		run(OP_RET_NEAR);
		chk({sp, ext_instr_pointer}, {16'h0000, 32'h0000fff0});
	endtask : t_calls

	// Interrupt return, table relocation, interrupt entry and an entry past the limit
	task automatic t_int;
		u_mem.mem[21'h10000] = 16'h0abc;
		u_mem.mem[21'h10002] = 16'h3000;
		u_mem.mem[21'h10004] = 16'h0202;
		@(posedge clk);
		run(OP_INT_RETURN);
		chk({sp, cs, ext_instr_pointer}, {16'h0006, 16'h3000, 32'h00000abc});
		chk(flags, 32'h00000202);
		@(posedge clk);
		tbase <= 32'h00000400;
		tlim <= 16'h000f;
		run(OP_LOAD_TABLE);
		chk(base, 32'h00000400);
		chk(lim, 16'h000f);
		for (int a = 0; a < 6; a += 2)
			u_mem.mem[21'h10000 + a] = 16'h0000;
		u_mem.mem[21'h40c] = 16'h5555;
		u_mem.mem[21'h40e] = 16'h6000;
		@(posedge clk);
		vec <= 8'h03;
		tlim <= 16'hffff;
		run(OP_INT);
		chk(u_mem.mem[21'h10004], 16'h0202);
		chk({u_mem.mem[21'h10002], u_mem.mem[21'h10000]}, {16'h3000, 16'h0abc});
		chk({cs, ext_instr_pointer}, {16'h6000, 32'h00005555});
		chk({sp, flags}, {16'h0000, 32'h00000002});
		@(posedge clk);
		vec <= 8'h04;
		run(OP_INT);
		chk({got_fault, fvec, sp}, {1'b1, RMA_VEC_GEN_FLT, 16'h0000});
	endtask : t_int

	// Mask ignored outside real mode; a fresh reset returns to real mode defaults
	task automatic t_prot;
		@(posedge clk);
		prot <= 1'b1;
		seg <= 16'hffff;
		wr_req <= 1'b0;
		repeat (2) @(posedge clk);
		run(OP_MEM);
		chk({real_m, u_mem.last_addr_q}, {1'b0, 21'h10ffef});
		@(posedge clk);
		nrst <= 1'b0;
		prot <= 1'b0;
		mask_n <= 1'b1;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		t_reset;
	endtask : t_prot

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// Reset, then the scenarios in turn
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		mask_n = 1'b1;
		{prot, valid, opsz, a32, sref, wr_req} = 6'h00;
		{op, wt, vec} = 15'h0000;
		{seg, wdat, tcs, tip, tlim, ofs, tbase} = '0;
		ss = 16'h1000;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		t_reset;
		t_mem;
		t_fault;
		t_calls;
		t_int;
		t_prot;
		results;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#2000000;
		bad_count++;
		results;
	end
endmodule : tb
